//--- bench/link_partner.sv
// Link partner model: counts transmissions and answers those that want a response after a delay.
// Assumes it shares CORE_CLK with the engine; the bench sets codes and stalls.
module link_partner
  import net_xfer_pkg::*;
#(
  parameter int DLY = 10
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Engine side
  input  wire logic        tx_valid,
  input  wire tx_t         tx,
  output logic             link_ready,
  output logic             rsp_valid,
  output rsp_t             rsp,
  // Bench control
  input  wire logic        answer,
  input  wire logic        stall,
  input  wire logic [15:0] code,
  output int               tx_count
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] pend_q[$];
  int         wait_cnt;
  // Ready is the inverse of the stall request
  assign link_ready = !stall;
  // Queue ports that want an answer, reply in order after DLY cycles
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp <= '0;
      tx_count <= 0;
      wait_cnt <= 0;
      pend_q.delete();
    end else begin
      rsp_valid <= 1'b0;
      rsp <= ~rsp;  // Junk while no answer stands
      if (tx_valid) begin
        tx_count <= tx_count + 1;
        if (tx.req.want_rsp && answer)
          pend_q.push_back(tx.port);
      end
      if (pend_q.size() > 0) begin
        wait_cnt <= wait_cnt + 1;
        if (wait_cnt == DLY) begin
          rsp_valid <= 1'b1;
          rsp <= '{port: pend_q.pop_front(), code: code};
          wait_cnt <= 0;
        end
      end
    end
  end
endmodule : link_partner

//--- bench/tb_top.sv
// Self-checking bench for the port engine against the link partner model.
// Assumes short ticks: 4 cycles a tick, 4 ticks an attempt, answers 4 cycles after a send.
module tb_top import net_xfer_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, wr, rd, ans, stl, txv, rspv, rdy;
  logic [3:0]  addr;
  logic [15:0] wdata, rdata, code, v;
  tx_t         tx, last_tx;
  rsp_t        rsp;
  int          failures = 0, compares = 0, ntx, cyc = 0;
  // Clock and cycle count
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  // Keep the last transmission seen
  always @(posedge clk)
    if (txv === 1'b1) last_tx <= tx;
  net_xfer_port_engine #(.TICK_CYC(4), .ATTEMPT(4)) uut (
    .CORE_CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata), .LINK_READY(rdy), .TX_VALID(txv), .TX(tx),
    .RSP_VALID(rspv), .RSP(rsp));
  link_partner #(.DLY(4)) lp (.clk(clk), .rst(rst), .tx_valid(txv), .tx(tx), .link_ready(rdy),
    .rsp_valid(rspv), .rsp(rsp), .answer(ans), .stall(stl), .code(code), .tx_count(ntx));
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rd_reg
  task automatic launch(input logic k, input logic [7:0] nd, un, input logic [2:0] p,
                        input logic [3:0] rt, input logic nr, input logic [15:0] tm, cn);
    wr_reg(OFS_CW0, cn);
    wr_reg(4'h1, 16'h0002);
    wr_reg(4'h2, {nd, un});
    wr_reg(4'h3, {nr, 4'h0, p, 4'h0, rt});
    wr_reg(OFS_CW4, tm);
    wr_reg(OFS_CMD, {15'h0000, k});
  endtask : launch
  task automatic wait_done(input int p, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      rd_reg(OFS_FLAGS);
      if (v[p] === 1'b1) break;
    end
    if (i == lim) begin
      failures++;
      $display("unexpected wait: port %0d never enabled", p);
      tally_and_finish();
    end
  endtask : wait_done
  task automatic t_reset;
    rd_reg(OFS_FLAGS);
    chk("flags", v, 16'h00FF);
    for (int i = 0; i < 8; i++) begin
      rd_reg(OFS_CC0 + i[3:0]);
      chk("code", v, 16'h0000);
    end
    wr_reg(OFS_FLAGS, 16'h1234);
    rd_reg(OFS_FLAGS);
    chk("ro flags", v, 16'h00FF);
    rd_reg(4'h7);
    chk("unmapped", v, 16'h0000);
    $display("test reset done");
  endtask : t_reset
  task automatic t_send;
    logic [15:0] cs [3] = '{16'h0000, 16'h0123, 16'h0000};
    logic [15:0] ef [3] = '{16'h00FF, 16'h04FF, 16'h00FF};
    int n0;
    for (int j = 0; j < 3; j++) begin
      code <= cs[j];
      n0 = ntx;
      launch(KIND_SEND, 8'h05, 8'h13, 3'd2, 4'h1, 1'b0, 16'h0064, 16'h03DE);
      rd_reg(OFS_FLAGS);
      chk("busy flags", v, 16'h00FB);
      rd_reg(OFS_CC0 + 4'h2);
      chk("running code", v, 16'h0000);
      wait_done(2, 50);
      rd_reg(OFS_FLAGS);
      chk("done flags", v, ef[j]);
      rd_reg(OFS_CC0 + 4'h2);
      chk("done code", v, cs[j]);
      chk("tx once", 16'(ntx - n0), 16'h0001);
    end
    chk("tx port", 16'(last_tx.port), 16'h0002);
    chk("tx count", last_tx.req.count, 16'h03DE);
    chk("tx net", 16'(last_tx.req.net), 16'h0002);
    chk("tx addr", {last_tx.req.node, 3'b000, last_tx.req.to_cpu, last_tx.req.bus_unit}, 16'h0503);
    chk("tx kind", 16'({last_tx.req.kind, last_tx.req.want_rsp}), 16'h0001);
    $display("test send done");
  endtask : t_send
  task automatic t_bcast;
    launch(KIND_SEND, 8'hFF, 8'h00, 3'd0, 4'h2, 1'b0, 16'h0064, 16'h02D7);
    wait_done(0, 4);
    chk("bcast rsp", 16'(last_tx.req.want_rsp), 16'h0000);
    chk("bcast count", last_tx.req.count, 16'h02D7);
    rd_reg(OFS_CC0);
    chk("bcast code", v, 16'h0000);
    launch(KIND_SEND, 8'h05, 8'h10, 3'd0, 4'h0, 1'b1, 16'h0064, 16'h0001);
    wait_done(0, 4);
    chk("no rsp wanted", 16'(last_tx.req.want_rsp), 16'h0000);
    $display("test broadcast done");
  endtask : t_bcast
  task automatic t_reject;
    logic [7:0]  nd [4] = '{8'h00, 8'h05, 8'hFF, 8'h80};
    logic [7:0]  un [4] = '{8'h00, 8'h05, 8'h00, 8'h00};
    logic [15:0] cc [4] = '{CC_SELF, CC_BAD_ADDR, CC_BAD_ADDR, CC_BAD_ADDR};
    int n0;
    for (int j = 0; j < 4; j++) begin
      n0 = ntx;
      launch(j == 2, nd[j], un[j], 3'd5, 4'h0, 1'b0, 16'h0000, 16'h0001);
      rd_reg(OFS_FLAGS);
      chk("reject flags", v, 16'h20FF);
      rd_reg(OFS_CC0 + 4'h5);
      chk("reject code", v, cc[j]);
      chk("reject tx", 16'(ntx - n0), 16'h0000);
    end
    $display("test reject done");
  endtask : t_reject
  task automatic t_recv;
    code <= 16'h0000;
    launch(KIND_RECV, 8'h05, 8'h12, 3'd6, 4'h0, 1'b0, 16'h000A, 16'h0001);
    wait_done(6, 50);
    chk("recv kind", 16'({last_tx.req.kind, last_tx.req.want_rsp}), 16'h0003);
    chk("recv addr", {last_tx.req.node, 3'b000, last_tx.req.to_cpu, last_tx.req.bus_unit}, 16'h0502);
    $display("test receive done");
  endtask : t_recv
  task automatic t_retry;
    int n0, t0;
    ans <= 1'b0;
    n0 = ntx;
    launch(KIND_SEND, 8'h05, 8'h00, 3'd1, 4'h3, 1'b0, 16'h0064, 16'h0010);
    wait_done(1, 200);
    chk("retry tx", 16'(ntx - n0), 16'h0004);
    chk("cpu addr", {last_tx.req.node, 3'b000, last_tx.req.to_cpu, last_tx.req.bus_unit}, 16'h0510);
    rd_reg(OFS_CC0 + 4'h1);
    chk("retry code", v, CC_NO_RSP);
    n0 = ntx;
    launch(KIND_SEND, 8'h05, 8'h00, 3'd4, 4'hF, 1'b0, 16'h0000, 16'h0010);
    t0 = cyc;
    wait_done(4, 60);
    chk("default time", 16'((cyc - t0 >= 70) && (cyc - t0 <= 90)), 16'h0001);
    chk("capped tx", 16'(ntx - n0 < 16), 16'h0001);
    rd_reg(OFS_FLAGS);
    chk("timeout flags", v, 16'h32FF);
    ans <= 1'b1;
    $display("test retry done");
  endtask : t_retry
  task automatic t_ports;
    int n0;
    stl <= 1'b1;
    n0 = ntx;
    launch(KIND_SEND, 8'h05, 8'h10, 3'd3, 4'h0, 1'b0, 16'h0064, 16'h0002);
    launch(KIND_SEND, 8'h06, 8'h11, 3'd7, 4'h0, 1'b0, 16'h0064, 16'h0003);
    launch(KIND_SEND, 8'h07, 8'h10, 3'd3, 4'h0, 1'b0, 16'h0064, 16'h0004);
    rd_reg(OFS_FLAGS);
    chk("two busy", v, 16'h3277);
    chk("stalled tx", 16'(ntx - n0), 16'h0000);
    stl <= 1'b0;
    wait_done(3, 50);
    wait_done(7, 50);
    chk("ports tx", 16'(ntx - n0), 16'h0002);
    $display("test ports done");
  endtask : t_ports
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // Main sequence
  initial begin
    rst = 1'b1;
    {wr, rd, ans, stl} = 4'b0010;
    addr = 4'h0;
    wdata = 16'h0000;
    code = 16'h0000;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_send();
    t_bcast();
    t_reject();
    t_recv();
    t_retry();
    t_ports();
    tally_and_finish();
  end
endmodule : tb_top

//--- rtl/net_xfer_pkg.sv
// Constants and carrier types of the network transfer port engine.
// Assumes one 20 MHz core clock and a link engine on the same clock.
package net_xfer_pkg;
  localparam int NPORT = 8;
  // Register word addresses
  localparam logic [3:0] OFS_CW0   = 4'h0;
  localparam logic [3:0] OFS_CW4   = 4'h4;
  localparam logic [3:0] OFS_CMD   = 4'h5;
  localparam logic [3:0] OFS_FLAGS = 4'h6;
  localparam logic [3:0] OFS_CC0   = 4'h8;
  // Tick of 0.1 s derived from the clock rate
  localparam int CLK_HZ      = 20_000_000;
  localparam int TICK_MS     = 100;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam logic [15:0] DEF_TMO       = 16'h0014;
  localparam int          ATTEMPT_TICKS = 5;
  // Address decode values
  localparam logic [7:0] NODE_LOCAL   = 8'h00;
  localparam logic [7:0] NODE_BCAST   = 8'hFF;
  localparam logic [7:0] NODE_MAX_DEF = 8'h7E;
  localparam logic [7:0] UNIT_CPU     = 8'h00;
  localparam logic [7:0] UNIT_BUS_LO  = 8'h10;
  localparam logic [7:0] UNIT_BUS_HI  = 8'h1F;
  // Fourth control word fields
  localparam int NRSP_BIT  = 15;
  localparam int PORT_LSB  = 8;
  localparam int RETRY_LSB = 0;
  // Completion codes raised by the engine itself
  localparam logic [15:0] CC_OK       = 16'h0000;
  localparam logic [15:0] CC_SELF     = 16'h0101;
  localparam logic [15:0] CC_BAD_ADDR = 16'h0102;
  localparam logic [15:0] CC_NO_RSP   = 16'h0205;

  typedef enum logic {KIND_SEND = 1'b0, KIND_RECV = 1'b1} kind_t;
  typedef enum logic [1:0] {P_IDLE = 2'b00, P_TX = 2'b01, P_WAIT = 2'b11} pstate_t;

  typedef struct packed {
    kind_t       kind;
    logic        want_rsp;
    logic        to_cpu;
    logic [3:0]  bus_unit;
    logic [7:0]  net;
    logic [7:0]  node;
    logic [15:0] count;
  } req_t;

  typedef struct packed {
    logic [2:0] port;
    req_t       req;
  } tx_t;

  typedef struct packed {
    logic [2:0]  port;
    logic [15:0] code;
  } rsp_t;
endpackage : net_xfer_pkg

//--- rtl/net_xfer_port_engine.sv
// Eight-port network send/receive request engine with status words.
// Assumes the link engine runs on CORE_CLK and answers on RSP_VALID.
//
// Local design decisions: the register addresses and the address-and-strobe port.

module net_xfer_port_engine
  import net_xfer_pkg::*;
#(
  parameter int         TICK_CYC = TICK_CYCLES,
  parameter int         ATTEMPT  = ATTEMPT_TICKS,
  parameter logic [7:0] OWN_NET  = 8'h01,
  parameter logic [7:0] OWN_NODE = 8'h01,
  parameter logic [7:0] NODE_MAX = NODE_MAX_DEF
) (
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  // Register port
  input  wire logic [3:0]  REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [15:0] REG_RDATA,
  // Link side
  input  wire logic        LINK_READY,
  output logic             TX_VALID,
  output tx_t              TX,
  input  wire logic        RSP_VALID,
  input  wire rsp_t        RSP
);
  logic [31:0] tick_cnt_ff, nxt_tick_cnt;
  logic        tick_ff, nxt_tick;
  logic [15:0] cw_ff [5];
  logic [15:0] nxt_cw [5];
  logic [15:0] rdata_ff, nxt_rdata;
  logic        txv_ff, nxt_txv;
  tx_t         tx_ff, nxt_tx;
  pstate_t     st_ff [NPORT];
  pstate_t     nxt_st [NPORT];
  req_t        req_ff [NPORT];
  req_t        nxt_req [NPORT];
  logic [3:0]  rty_ff [NPORT];
  logic [3:0]  nxt_rty [NPORT];
  logic [15:0] tmo_ff [NPORT];
  logic [15:0] nxt_tmo [NPORT];
  logic [7:0]  att_ff [NPORT];
  logic [7:0]  nxt_att [NPORT];
  logic [15:0] code_ff [NPORT];
  logic [15:0] nxt_code [NPORT];
  logic             err_ff [NPORT];
  logic             nxt_err [NPORT];
  logic [NPORT-1:0] err_vec, en, acc, grant;
  logic        issue, node_ok, unit_ok, self_hit, bcast, rej, gfound;
  logic [2:0]  iport;
  logic [15:0] rej_code, itmo;
  req_t        ireq;

  // Assertions sample on the core clock and rest during reset
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  assign TX_VALID  = txv_ff;
  assign TX        = tx_ff;
  assign REG_RDATA = rdata_ff;

  // Tenth-second tick divider
  always_comb begin
    nxt_tick     = (tick_cnt_ff == 32'(TICK_CYC - 1));
    nxt_tick_cnt = nxt_tick ? '0 : tick_cnt_ff + 32'd1;
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b0;
    end else begin
      tick_cnt_ff <= nxt_tick_cnt;
      tick_ff     <= nxt_tick;
    end
  end

  // Request decode from the staged control words and the command write
  always_comb begin
    issue         = REG_WR && (REG_ADDR == OFS_CMD);
    iport         = cw_ff[3][PORT_LSB +: 3];
    ireq.kind     = kind_t'(REG_WDATA[0]);
    ireq.count    = cw_ff[0];
    ireq.net      = cw_ff[1][7:0];
    ireq.node     = cw_ff[2][15:8];
    ireq.to_cpu   = (cw_ff[2][7:0] == UNIT_CPU);
    ireq.bus_unit = 4'(cw_ff[2][7:0] - UNIT_BUS_LO);
    bcast   = (ireq.node == NODE_BCAST);
    node_ok = bcast || (ireq.node <= NODE_MAX);
    unit_ok = ireq.to_cpu || (cw_ff[2][7:0] >= UNIT_BUS_LO && cw_ff[2][7:0] <= UNIT_BUS_HI);
    ireq.want_rsp = !bcast && (ireq.kind == KIND_RECV || !cw_ff[3][NRSP_BIT]);
    self_hit = (ireq.kind == KIND_SEND) && ireq.to_cpu &&
               (ireq.node == NODE_LOCAL || (ireq.node == OWN_NODE && ireq.net == OWN_NET));
    rej      = self_hit || !node_ok || !unit_ok || (bcast && ireq.kind == KIND_RECV);
    rej_code = self_hit ? CC_SELF : CC_BAD_ADDR;
    itmo     = (cw_ff[4] == 16'h0000) ? DEF_TMO : cw_ff[4];
  end

  // Link grant, lowest pending port first
  always_comb begin
    grant  = '0;
    gfound = 1'b0;
    nxt_tx = tx_ff;
    for (int i = 0; i < NPORT; i++) begin
      if (!gfound && LINK_READY && st_ff[i] == P_TX) begin
        grant[i]    = 1'b1;
        gfound      = 1'b1;
        nxt_tx.port = 3'(i);
        nxt_tx.req  = req_ff[i];
      end
    end
    nxt_txv = gfound;
  end

  // Per-port request state
  generate
    for (genvar p = 0; p < NPORT; p++) begin : g_port
      assign en[p]  = (st_ff[p] == P_IDLE);
      assign acc[p] = issue && en[p] && (iport == 3'(p));
      // error flag into the status word
      assign err_vec[p] = err_ff[p];

      always_comb begin
        nxt_st[p]   = st_ff[p];
        nxt_req[p]  = req_ff[p];
        nxt_rty[p]  = rty_ff[p];
        nxt_tmo[p]  = tmo_ff[p];
        nxt_att[p]  = att_ff[p];
        nxt_code[p] = code_ff[p];
        nxt_err[p]  = err_ff[p];
        case (st_ff[p])
          P_IDLE: begin
            if (acc[p] && rej) begin
              nxt_code[p] = rej_code;
              nxt_err[p]  = 1'b1;
            end else if (acc[p]) begin
              nxt_st[p]   = P_TX;
              nxt_req[p]  = ireq;
              nxt_rty[p]  = cw_ff[3][RETRY_LSB +: 4];
              nxt_tmo[p]  = itmo;
              nxt_code[p] = CC_OK;
              nxt_err[p]  = 1'b0;
            end
          end
          P_TX: begin
            if (grant[p] && req_ff[p].want_rsp) begin
              nxt_st[p]  = P_WAIT;
              nxt_att[p] = 8'(ATTEMPT);
            end else if (grant[p]) begin
              nxt_st[p] = P_IDLE;
            end
          end
          P_WAIT: begin
            if (RSP_VALID && RSP.port == 3'(p)) begin
              nxt_st[p]   = P_IDLE;
              nxt_code[p] = RSP.code;
              nxt_err[p]  = (RSP.code != CC_OK);
            end else if (tick_ff) begin
              nxt_tmo[p] = tmo_ff[p] - 16'd1;
              nxt_att[p] = att_ff[p] - 8'd1;
              if (tmo_ff[p] == 16'd1 || (att_ff[p] == 8'd1 && rty_ff[p] == 4'd0)) begin
                nxt_st[p]   = P_IDLE;
                nxt_code[p] = CC_NO_RSP;
                nxt_err[p]  = 1'b1;
              end else if (att_ff[p] == 8'd1) begin
                nxt_st[p]  = P_TX;
                nxt_rty[p] = rty_ff[p] - 4'd1;
              end
            end
          end
          default: nxt_st[p] = P_IDLE;
        endcase
      end

      always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
          st_ff[p]   <= P_IDLE;
          req_ff[p]  <= '0;
          rty_ff[p]  <= '0;
          tmo_ff[p]  <= '0;
          att_ff[p]  <= '0;
          code_ff[p] <= CC_OK;
          err_ff[p]  <= 1'b0;
        end else begin
          st_ff[p]   <= nxt_st[p];
          req_ff[p]  <= nxt_req[p];
          rty_ff[p]  <= nxt_rty[p];
          tmo_ff[p]  <= nxt_tmo[p];
          att_ff[p]  <= nxt_att[p];
          code_ff[p] <= nxt_code[p];
          err_ff[p]  <= nxt_err[p];
        end
      end

      // Status assertions per port
      AST_CODE_ZERO_BUSY: assert property (st_ff[p] != P_IDLE |-> code_ff[p] == CC_OK)
        else $error("Completion code not zero while busy");
      AST_ERR_FROM_CODE: assert property (en[p] |-> err_ff[p] == (code_ff[p] != CC_OK))
        else $error("Error flag disagrees with code");
      AST_STATUS_HOLD: assert property (en[p] && !acc[p] |=> $stable(code_ff[p]) && $stable(err_ff[p]))
        else $error("Status changed without a new request");
      AST_ACCEPT_BUSY: assert property (acc[p] && !rej |=> !en[p] && code_ff[p] == CC_OK)
        else $error("Accepted port still enabled");
      AST_SELF_REJECT: assert property (acc[p] && self_hit |=> en[p] && code_ff[p] == CC_SELF)
        else $error("Send to own controller not rejected");
      AST_DEFAULT_TMO: assert property (acc[p] && !rej && cw_ff[4] == 16'h0000 |=> tmo_ff[p] == DEF_TMO)
        else $error("Zero timeout did not select default");
      AST_BCAST_DONE: assert property (grant[p] && req_ff[p].node == NODE_BCAST |=> en[p])
        else $error("Broadcast waited for a response");
      AST_RETRY: assert property (st_ff[p] == P_WAIT && tick_ff && !(RSP_VALID && RSP.port == 3'(p))
                                  && att_ff[p] == 8'd1 && rty_ff[p] != 4'd0 && tmo_ff[p] != 16'd1
                                  |=> st_ff[p] == P_TX && rty_ff[p] == $past(rty_ff[p]) - 4'd1)
        else $error("Retry not taken");
      AST_TIMEOUT: assert property (st_ff[p] == P_WAIT && tick_ff && tmo_ff[p] == 16'd1
                                    && !(RSP_VALID && RSP.port == 3'(p))
                                    |=> en[p] && code_ff[p] == CC_NO_RSP)
        else $error("Timeout did not end the request");
    end
  endgenerate

  // Control words, link strobe and read data
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      nxt_cw[i] = (REG_WR && REG_ADDR == OFS_CW0 + 4'(i)) ? REG_WDATA : cw_ff[i];
    end
    nxt_rdata = rdata_ff;
    if (REG_RD) begin
      nxt_rdata = 16'h0000;
      if (REG_ADDR <= OFS_CW4) begin
        nxt_rdata = cw_ff[REG_ADDR[2:0]];
      end else if (REG_ADDR == OFS_FLAGS) begin
        nxt_rdata = {err_vec, en};
      end else if (REG_ADDR >= OFS_CC0) begin
        nxt_rdata = code_ff[REG_ADDR[2:0]];
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < 5; i++) begin
        cw_ff[i] <= 16'h0000;
      end
      rdata_ff <= 16'h0000;
      txv_ff   <= 1'b0;
      tx_ff    <= '0;
    end else begin
      cw_ff    <= nxt_cw;
      rdata_ff <= nxt_rdata;
      txv_ff   <= nxt_txv;
      tx_ff    <= nxt_tx;
    end
  end

  sequence s_grant_any;
    LINK_READY && gfound;
  endsequence

  AST_TX_PORT: assert property (s_grant_any |=> TX_VALID && $past(grant) == (NPORT'(1) << TX.port))
    else $error("Transmit port differs from grant");
  AST_FLAGS_READ: assert property (REG_RD && REG_ADDR == OFS_FLAGS
                                   |=> REG_RDATA == {$past(err_vec), $past(en)})
    else $error("Flags word read wrong");
endmodule : net_xfer_port_engine
